// >>> pkg/umsr_defines.vh
/*
 Register offsets, field positions, reset values and timing counts for the UART
 modem status / FIFO level register block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef UMSR_DEFINES_VH
`define UMSR_DEFINES_VH

// Byte addresses on the AXI4-Lite bus, one aligned word each
`define UMSR_OFF_DATA_DIVLO  8'h00
`define UMSR_OFF_IEN_DIVHI   8'h04
`define UMSR_OFF_LINE_CTRL   8'h0c
`define UMSR_OFF_MODEM_CTRL  8'h10
`define UMSR_OFF_LINE_STAT   8'h14
`define UMSR_OFF_MODEM_STAT  8'h18
`define UMSR_OFF_SCRATCH     8'h1c
`define UMSR_OFF_FEAT_CTRL   8'h20
`define UMSR_OFF_ENH_FEAT    8'h24
`define UMSR_OFF_PART_ID     8'h28
`define UMSR_OFF_PART_REV    8'h2c
`define UMSR_OFF_FIFO_LEVELS 8'h30
`define UMSR_OFF_RX_ERRCNT   8'h34
`define UMSR_OFF_STATUS_AUX  8'h38

// Field positions
`define UMSR_LINE_CTRL_DLAB  7
`define UMSR_LSR_FIFO_ERR    7
`define UMSR_IEN_MODEM       3
`define UMSR_MCR_RTS         1
`define UMSR_MCR_LOOP        4
`define UMSR_MCR_PRESCALE    7
`define UMSR_FEATURE_CONTROL_SWAP       6
`define UMSR_EFR_AUTO_CTS    7

// Reset values
`define UMSR_SCRATCH_RST     8'hff
`define UMSR_DIVISOR_RST     16'h0001
`define UMSR_DIVISOR_LOW_RST 8'h01
`define UMSR_DIVISOR_HIGH_RST 8'h00

// Counter mode codes
`define UMSR_MODE_TX         2'h1
`define UMSR_MODE_ALT        2'h3

// Baud generator constants
`define UMSR_OVERSAMPLE      5'h10
`define UMSR_PRESCALE_DIV    3'h4

// AXI responses
`define UMSR_RESP_OKAY       2'h0
`define UMSR_RESP_SLVERR     2'h2

`endif

// >>> rtl/umsr_baud_gen.v
/*
 Baud tick generator: optional divide-by-four prescaler, then divisor, then 16x.
 Assumes one clock; the divisor and prescale select come from registers.
*/
`timescale 1ns/1ps
`include "umsr_defines.vh"

module umsr_baud_gen (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Control
  input  wire        prescale_en,
  input  wire [15:0] divisor,
  // Ticks
  output reg         sample_tick_ff,
  output reg         baud_tick_ff
);

  reg  [1:0]  pre_cnt_ff;
  reg  [15:0] div_cnt_ff;
  reg  [3:0]  os_cnt_ff;
  wire        pre_tick;
  wire        div_tick;

  // Divisor zero stops the generator instead of running at an undefined rate
  assign pre_tick = !prescale_en || (pre_cnt_ff == 2'h3); // R19
  assign div_tick = pre_tick && (divisor != 16'h0000) && (div_cnt_ff >= divisor - 16'h0001);

  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_ff     <= 2'h0;
      div_cnt_ff     <= 16'h0000;
      os_cnt_ff      <= 4'h0;
      sample_tick_ff <= 1'b0;
      baud_tick_ff   <= 1'b0;
    end else begin
      pre_cnt_ff     <= prescale_en ? pre_cnt_ff + 2'h1 : 2'h0; // R19
      sample_tick_ff <= div_tick;
      baud_tick_ff   <= div_tick && (os_cnt_ff == 4'hf); // R18
      if (pre_tick) begin
        div_cnt_ff <= div_tick ? 16'h0000 : div_cnt_ff + 16'h0001;
      end
      if (div_tick) begin
        os_cnt_ff <= os_cnt_ff + 4'h1;
      end
    end
  end

endmodule

// >>> rtl/umsr_regs.v
/*
 Per-channel register logic: modem status with deltas and loopback, receive FIFO
 error flag, scratchpad and its swap with mode select and FIFO level, hysteresis
 decode, baud divisor, part identification, all behind an AXI4-Lite slave.
 Assumes modem inputs come from pins (active low) and FIFO information from
 same-clock logic. The documented device is addressed here by AXI byte addresses.
*/
// The register offsets and the AXI4-Lite slave port were left to the implementer.
//
// Function
// R1 - Error flag set when any FIFO byte errored
// R2 - Error flag clears when no errored bytes
// R3 - CTS, DSR, CD deltas set on change; the code sets no deltas while loopback is on
// R4 - RI delta set on rising input only; the code sets no deltas while loopback is on
// R5 - Set delta plus enable raises modem interrupt
// R6 - Modem status read clears all deltas
// R7 - Auto CTS: high halts after character
// R8 - Status bits show inverted modem inputs
// R9 - Loopback maps control bits to status
// R10 - Scratchpad 8-bit, resets to ff
// R11 - Swap bit redirects writes to mode select
// R12 - Mode bits choose level counter source
// R13 - Alternating mode reads receive then transmit
// R14 - Mode write restarts alternating sequence
// R15 - Hysteresis from four-bit code table
// R16 - Swap bit makes reads return level
// R17 - Level register distinct from data count
// R18 - Divisor is high and low concatenated
// R19 - Modem control bit 7 selects prescaler
// R20 - Fixed part code and revision registers
// R21 - Host zeroes divisor before reading identity
// R22 - Line control bit 7 selects divisor
`timescale 1ns/1ps
`include "umsr_defines.vh"

module umsr_regs #(
  parameter [7:0] PART_CODE = 8'h5a, // Arbitrary value
  parameter [7:0] PART_REV  = 8'h03  // Arbitrary value
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Modem pins, active low
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ri_n,
  input  wire        cd_n,
  // FIFO side information
  input  wire [7:0]  rx_fifo_count,
  input  wire [7:0]  tx_fifo_count,
  input  wire        rx_push,
  input  wire        rx_push_err,
  input  wire        rx_pop,
  input  wire        rx_pop_err,
  input  wire        tx_char_done,
  // Block outputs
  output reg         modem_irq_ff,
  output reg         tx_halt_ff,
  output reg  [5:0]  rts_hysteresis_ff,
  output reg         baud_tick_ff,
  output reg         sample_tick_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  line_ctrl_ff;
  reg  [7:0]  modem_ctrl_ff;
  reg  [7:0]  int_enable_ff;
  reg  [7:0]  feat_ctrl_ff;
  reg  [7:0]  enh_feat_ff;
  reg  [7:0]  scratch_pad_ff;
  reg  [7:0]  enh_mode_ff;
  reg  [7:0]  divisor_low_ff;
  reg  [7:0]  divisor_high_ff;
  reg  [3:0]  delta_ff;
  reg  [7:0]  rx_err_cnt_ff;
  reg         alt_tx_next_ff;
  reg  [3:0]  pin_meta_ff;
  reg  [3:0]  pin_sync_ff;
  reg  [3:0]  pin_prev_ff;

  reg  [7:0]  aw_addr_ff;
  reg         aw_held_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_held_ff;

  wire        baud_tick;
  wire        sample_tick;
  wire [3:0]  modem_level;
  wire [3:0]  modem_change;
  wire [7:0]  modem_status;
  wire [7:0]  line_status;
  wire [7:0]  fifo_fill_level;
  wire        swap;
  wire        dlab;
  wire        wr_go;
  wire        rd_go;
  wire        msr_read;
  wire        lvl_read;
  wire        wr_lane0;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  reg  [5:0]  nxt_hyst;

  assign swap = feat_ctrl_ff[`UMSR_FEATURE_CONTROL_SWAP];
  assign dlab = line_ctrl_ff[`UMSR_LINE_CTRL_DLAB];

  ////////////////////////////////////////////////////////////////////////////////
  // Modem inputs: pins pass two flops before any logic reads them

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 4'hf;
      pin_sync_ff <= 4'hf;
      pin_prev_ff <= 4'hf;
    end else begin
      pin_meta_ff <= {cd_n, ri_n, dsr_n, cts_n};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // Order cts, dsr, ri, cd; status level is active high
  assign modem_level = modem_ctrl_ff[`UMSR_MCR_LOOP] ?
                       {modem_ctrl_ff[3], modem_ctrl_ff[2], modem_ctrl_ff[0], modem_ctrl_ff[1]} : // R9
                       ~pin_sync_ff; // R8

  // Delta bits 0,1,3 on any edge; bit 2 only when the RI pin rises
  assign modem_change[0] = pin_sync_ff[0] ^ pin_prev_ff[0]; // R3
  assign modem_change[1] = pin_sync_ff[1] ^ pin_prev_ff[1]; // R3
  assign modem_change[2] = pin_sync_ff[2] & ~pin_prev_ff[2]; // R4
  assign modem_change[3] = pin_sync_ff[3] ^ pin_prev_ff[3]; // R3

  assign modem_status = {modem_level, delta_ff}; // R8

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO error tracking: count errored bytes held in the FIFO

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_err_cnt_ff <= 8'h00;
    end else begin
      case ({rx_push & rx_push_err, rx_pop & rx_pop_err})
        2'b10:   rx_err_cnt_ff <= rx_err_cnt_ff + 8'h01; // R1
        2'b01:   rx_err_cnt_ff <= rx_err_cnt_ff - 8'h01; // R2
        default: rx_err_cnt_ff <= rx_err_cnt_ff;
      endcase
    end
  end

  assign line_status = {(rx_err_cnt_ff != 8'h00), 7'h00}; // R1 R2

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO level selection

  assign fifo_fill_level = (enh_mode_ff[1:0] == `UMSR_MODE_TX) ? tx_fifo_count : // R12
                           (enh_mode_ff[1:0] == `UMSR_MODE_ALT && alt_tx_next_ff) ? tx_fifo_count : // R13
                           rx_fifo_count; // R12

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, one of each at a time

  assign wr_go    = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign rd_go    = s_axi_arvalid && s_axi_arready;
  assign wr_lane0 = w_strb_ff[0];
  assign msr_read = rd_go && (s_axi_araddr == `UMSR_OFF_MODEM_STAT);
  assign lvl_read = rd_go && (s_axi_araddr == `UMSR_OFF_SCRATCH) && swap;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UMSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff    <= s_axi_awaddr;
        aw_held_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        w_held_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff > `UMSR_OFF_ENH_FEAT || aw_addr_ff[1:0] != 2'h0 ||
                         aw_addr_ff == `UMSR_OFF_LINE_STAT || aw_addr_ff == `UMSR_OFF_MODEM_STAT) ?
                        `UMSR_RESP_SLVERR : `UMSR_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes, low byte lane only
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_ctrl_ff    <= 8'h00;
      modem_ctrl_ff   <= 8'h00;
      int_enable_ff   <= 8'h00;
      feat_ctrl_ff    <= 8'h00;
      enh_feat_ff     <= 8'h00;
      scratch_pad_ff  <= `UMSR_SCRATCH_RST; // R10
      enh_mode_ff     <= 8'h00;
      divisor_low_ff  <= `UMSR_DIVISOR_LOW_RST;
      divisor_high_ff <= `UMSR_DIVISOR_HIGH_RST;
    end else if (wr_go && wr_lane0) begin
      case (aw_addr_ff)
        `UMSR_OFF_DATA_DIVLO:  if (dlab) divisor_low_ff <= w_data_ff[7:0]; // R22
        `UMSR_OFF_IEN_DIVHI: begin
          if (dlab) begin
            divisor_high_ff <= w_data_ff[7:0]; // R22
          end else begin
            int_enable_ff <= w_data_ff[7:0];
          end
        end
        `UMSR_OFF_LINE_CTRL:   line_ctrl_ff  <= w_data_ff[7:0];
        `UMSR_OFF_MODEM_CTRL:  modem_ctrl_ff <= w_data_ff[7:0];
        `UMSR_OFF_SCRATCH: begin
          if (swap) begin
            enh_mode_ff <= w_data_ff[7:0]; // R11
          end else begin
            scratch_pad_ff <= w_data_ff[7:0]; // R10
          end
        end
        `UMSR_OFF_FEAT_CTRL:   feat_ctrl_ff  <= w_data_ff[7:0];
        `UMSR_OFF_ENH_FEAT:    enh_feat_ff   <= w_data_ff[7:0];
        default:               line_ctrl_ff  <= line_ctrl_ff;
      endcase
    end
  end

  // Alternating level sequence: restart on mode write, step on each level read
  always @(posedge aclk) begin
    if (!aresetn) begin
      alt_tx_next_ff <= 1'b0;
    end else if (wr_go && wr_lane0 && aw_addr_ff == `UMSR_OFF_SCRATCH && swap) begin
      alt_tx_next_ff <= 1'b0; // R14
    end else if (lvl_read) begin
      alt_tx_next_ff <= ~alt_tx_next_ff; // R13
    end
  end

  // Delta flags: a change in the read cycle survives the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      delta_ff <= 4'h0;
    end else begin
      delta_ff <= (msr_read ? 4'h0 : delta_ff) | (modem_ctrl_ff[`UMSR_MCR_LOOP] ? 4'h0 : modem_change); // R6 R3 R4
    end
  end

  // Read mux
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `UMSR_OFF_DATA_DIVLO:  rd_byte = dlab ? divisor_low_ff : 8'h00; // R22
      `UMSR_OFF_IEN_DIVHI:   rd_byte = dlab ? divisor_high_ff : int_enable_ff; // R22
      `UMSR_OFF_LINE_CTRL:   rd_byte = line_ctrl_ff;
      `UMSR_OFF_MODEM_CTRL:  rd_byte = modem_ctrl_ff;
      `UMSR_OFF_LINE_STAT:   rd_byte = line_status;
      `UMSR_OFF_MODEM_STAT:  rd_byte = modem_status;
      `UMSR_OFF_SCRATCH:     rd_byte = swap ? fifo_fill_level : scratch_pad_ff; // R16 R17
      `UMSR_OFF_FEAT_CTRL:   rd_byte = feat_ctrl_ff;
      `UMSR_OFF_ENH_FEAT:    rd_byte = enh_feat_ff;
      `UMSR_OFF_PART_ID:     rd_byte = PART_CODE; // R20
      `UMSR_OFF_PART_REV:    rd_byte = PART_REV; // R20
      default:               rd_hit  = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UMSR_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_hit ? `UMSR_RESP_OKAY : `UMSR_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hysteresis decode, interrupt, auto CTS

  always @* begin
    case ({enh_mode_ff[5:4], feat_ctrl_ff[1:0]}) // R15
      4'h0:    nxt_hyst = 6'h00;
      4'h1:    nxt_hyst = 6'h04;
      4'h2:    nxt_hyst = 6'h06;
      4'h3:    nxt_hyst = 6'h08;
      4'h4:    nxt_hyst = 6'h08;
      4'h5:    nxt_hyst = 6'h10;
      4'h6:    nxt_hyst = 6'h18;
      4'h7:    nxt_hyst = 6'h20;
      4'h8:    nxt_hyst = 6'h28;
      4'h9:    nxt_hyst = 6'h2c;
      4'ha:    nxt_hyst = 6'h30;
      4'hb:    nxt_hyst = 6'h34;
      4'hc:    nxt_hyst = 6'h0c;
      4'hd:    nxt_hyst = 6'h14;
      4'he:    nxt_hyst = 6'h1c;
      default: nxt_hyst = 6'h24;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      modem_irq_ff      <= 1'b0;
      tx_halt_ff        <= 1'b0;
      rts_hysteresis_ff <= 6'h00;
      baud_tick_ff      <= 1'b0;
      sample_tick_ff    <= 1'b0;
    end else begin
      modem_irq_ff      <= (delta_ff != 4'h0) && int_enable_ff[`UMSR_IEN_MODEM]; // R5
      rts_hysteresis_ff <= nxt_hyst; // R15
      baud_tick_ff      <= baud_tick;
      sample_tick_ff    <= sample_tick;
      // Halt only takes effect at a character boundary; resume is immediate
      if (!enh_feat_ff[`UMSR_EFR_AUTO_CTS] || modem_level[0]) begin
        tx_halt_ff <= 1'b0; // R7
      end else if (tx_char_done) begin
        tx_halt_ff <= 1'b1; // R7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Baud generator

  umsr_baud_gen u_baud (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .prescale_en    (modem_ctrl_ff[`UMSR_MCR_PRESCALE]), // R19
    .divisor        ({divisor_high_ff, divisor_low_ff}), // R18
    .sample_tick_ff (sample_tick),
    .baud_tick_ff   (baud_tick)
  );

endmodule

// >>> test/umsr_regs_checker.sv
/*
 Concurrent checks on the register block ports: bus answer timing, read data
 shape, hysteresis decode, auto CTS release and modem interrupt gating.
 Assumes it is bound to every umsr_regs instance and sees only its ports.
*/
`timescale 1ns/1ps
module umsr_regs_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Modem and outputs
  input wire        cts_n,
  input wire        modem_irq_ff,
  input wire        tx_halt_ff,
  input wire [5:0]  rts_hysteresis_ff,
  input wire        baud_tick_ff,
  input wire        sample_tick_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Coarse: any write at the interrupt enable offset arms the check
  reg ien_seen_ff;
  always @(posedge aclk) begin
    if (!aresetn)
      ien_seen_ff <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h04)
      ien_seen_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  a_busy_no_accept: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_hyst_table: assert property (rts_hysteresis_ff inside {6'h00, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10,
    6'h14, 6'h18, 6'h1c, 6'h20, 6'h24, 6'h28, 6'h2c, 6'h30, 6'h34})
    else $error("hysteresis outside table");
  a_cts_release: assert property (!cts_n [*5] |-> !tx_halt_ff)
    else $error("transmit halted while clear to send");
  a_irq_gated: assert property (modem_irq_ff |-> ien_seen_ff)
    else $error("modem interrupt without enable");
  a_baud_on_sample: assert property (baud_tick_ff |-> sample_tick_ff)
    else $error("bit tick without sample tick");

  c_write: cover property (s_axi_bvalid);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(modem_irq_ff));
  c_halt: cover property ($rose(tx_halt_ff));
endmodule

bind umsr_regs umsr_regs_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cts_n, .modem_irq_ff, .tx_halt_ff, .rts_hysteresis_ff, .baud_tick_ff, .sample_tick_ff);

// >>> test/umsr_modem_model.sv
/*
 Far-end modem: drives the four active-low status pins from asserted levels.
 Assumes the bench changes the requested levels right after a clock edge.
*/
`timescale 1ns/1ps
module umsr_modem_model (
  // Clock
  input wire       aclk,
  // Asserted lines: cts, dsr, ri, cd
  input wire [3:0] line_on,
  // Pins
  output reg       cts_n,
  output reg       dsr_n,
  output reg       ri_n,
  output reg       cd_n
);
  initial {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
  always @(posedge aclk) begin
    {cd_n, ri_n, dsr_n, cts_n} <= ~line_on;
  end
endmodule

// >>> test/tb_umsr_regs.sv
/*
 Self-checking bench for umsr_regs: AXI4-Lite register tasks, modem model,
 FIFO side pulses and baud tick measurement.
 Assumes the design answers within a few cycles and a 100 ns clock.
*/
`timescale 1ns/1ps
module tb_umsr_regs;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_fifo_count = 8'h00, tx_fifo_count = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'h0, line_on = 4'h0;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg         rx_push = 0, rx_push_err = 0, rx_pop = 0, rx_pop_err = 0, tx_char_done = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        cts_n, dsr_n, ri_n, cd_n, modem_irq_ff, tx_halt_ff, baud_tick_ff, sample_tick_ff;
  wire [5:0]  rts_hysteresis_ff;
  reg  [31:0] rd_data;
  reg  [1:0]  resp;
  integer     bad_count = 0, compares = 0, i, n;
  localparam [95:0] HYST = {6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, 6'h28,
                            6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};

  umsr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cts_n, .dsr_n, .ri_n, .cd_n,
    .rx_fifo_count, .tx_fifo_count, .rx_push, .rx_push_err, .rx_pop, .rx_pop_err, .tx_char_done,
    .modem_irq_ff, .tx_halt_ff, .rts_hysteresis_ff, .baud_tick_ff, .sample_tick_ff);
  umsr_modem_model u_modem (.aclk, .line_on, .cts_n, .dsr_n, .ri_n, .cd_n);

  initial forever #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    begin
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk_val(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task chk_resp(input [1:0] got, input [1:0] exp);
    begin
      chk_val({30'h0, got}, {30'h0, exp});
    end
  endtask

  // Both write channels offered together; bready held until the answer
  task wr(input [7:0] a, input [7:0] d);
    integer k;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          resp = s_axi_bresp;
          s_axi_bready <= 1'b0;
          k = 99;
        end
      end
      if (k != 100) begin
        bad_count = bad_count + 1;
        finish_test;
      end
      @(posedge aclk);
    end
  endtask

  task rd(input [7:0] a);
    integer k;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          rd_data = s_axi_rdata;
          resp = s_axi_rresp;
          s_axi_rready <= 1'b0;
          k = 99;
        end
      end
      if (k != 100) begin
        bad_count = bad_count + 1;
        finish_test;
      end
      @(posedge aclk);
    end
  endtask

  task rdx(input [7:0] a, input [7:0] e);
    begin
      rd(a);
      chk_resp(resp, 2'h0);
      chk_val(rd_data, {24'h0, e});
    end
  endtask

  // Cycles between two baud ticks, bounded
  task period(output integer p);
    integer k;
    begin
      k = 0;
      while (!baud_tick_ff && k < 3000) begin @(posedge aclk); k = k + 1; end
      @(posedge aclk);
      p = 1;
      while (!baud_tick_ff && k < 3000) begin @(posedge aclk); p = p + 1; k = k + 1; end
      if (k >= 3000) begin bad_count = bad_count + 1; finish_test; end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge aclk);
    bad_count = bad_count + 1;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rdx(8'h1c, 8'hff);
    rdx(8'h14, 8'h00);
    rd(8'h18);
    rdx(8'h18, 8'h00);
    wr(8'h0c, 8'h80); wr(8'h00, 8'h00); wr(8'h04, 8'h00); wr(8'h0c, 8'h00);
    rdx(8'h28, 8'h5a);
    rdx(8'h2c, 8'h03);
    wr(8'h28, 8'h77);
    chk_resp(resp, 2'h2);
    rdx(8'h28, 8'h5a);
    rd(8'h3c);
    chk_resp(resp, 2'h2);
    chk_val(rd_data, 32'h0);
    wr(8'h1c, 8'ha5);
    rdx(8'h1c, 8'ha5);
    // Level swap and counter modes
    rx_fifo_count <= 8'h11;
    tx_fifo_count <= 8'h22;
    wr(8'h20, 8'h40);
    wr(8'h1c, 8'h03);
    rdx(8'h1c, 8'h11); rdx(8'h1c, 8'h22); rdx(8'h1c, 8'h11);
    wr(8'h1c, 8'h03);
    rdx(8'h1c, 8'h11);
    wr(8'h1c, 8'h01);
    rdx(8'h1c, 8'h22); rdx(8'h1c, 8'h22);
    wr(8'h1c, 8'h00);
    rdx(8'h1c, 8'h11);
    wr(8'h1c, 8'h02);
    rdx(8'h1c, 8'h11);
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h20, 8'h40 | i[1:0]);
      wr(8'h1c, {2'h0, i[3:2], 4'h0});
      repeat (2) @(posedge aclk);
      chk_val(rts_hysteresis_ff, HYST[i*6 +: 6]);
    end
    wr(8'h20, 8'h00);
    rdx(8'h1c, 8'ha5);
    // Modem deltas and interrupt
    wr(8'h04, 8'h08);
    line_on <= 4'h1;
    repeat (6) @(posedge aclk);
    chk_val(modem_irq_ff, 1);
    rdx(8'h18, 8'h11);
    repeat (3) @(posedge aclk);
    chk_val(modem_irq_ff, 0);
    rdx(8'h18, 8'h10);
    line_on <= 4'h5;
    repeat (6) @(posedge aclk);
    rdx(8'h18, 8'h50);
    line_on <= 4'h1;
    repeat (6) @(posedge aclk);
    rdx(8'h18, 8'h14);
    line_on <= 4'hb;
    repeat (6) @(posedge aclk);
    rdx(8'h18, 8'hba);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h10, 8'h10 | (8'h01 << i));
      rdx(8'h18, (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : (8'h10 << i));
    end
    wr(8'h10, 8'h00);
    rd(8'h18);
    // Auto CTS: pin high halts after the character
    wr(8'h24, 8'h80);
    line_on <= 4'h0;
    repeat (6) @(posedge aclk);
    tx_char_done <= 1'b1;
    @(posedge aclk);
    tx_char_done <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_val(tx_halt_ff, 1);
    line_on <= 4'h1;
    repeat (6) @(posedge aclk);
    chk_val(tx_halt_ff, 0);
    // Receive error tags: one tagged byte, one clean
    rx_push <= 1'b1;
    rx_push_err <= 1'b1;
    @(posedge aclk);
    rx_push_err <= 1'b0;
    @(posedge aclk);
    rx_push <= 1'b0;
    rdx(8'h14, 8'h80);
    rx_pop <= 1'b1;
    @(posedge aclk);
    rx_pop <= 1'b0;
    rdx(8'h14, 8'h80);
    rx_pop <= 1'b1;
    rx_pop_err <= 1'b1;
    @(posedge aclk);
    rx_pop <= 1'b0;
    rx_pop_err <= 1'b0;
    rdx(8'h14, 8'h00);
    // Divisor window and baud rate
    wr(8'h0c, 8'h80);
    wr(8'h00, 8'h02);
    rdx(8'h00, 8'h02);
    wr(8'h0c, 8'h00);
    rdx(8'h00, 8'h00);
    rdx(8'h04, 8'h08);
    period(n);
    period(n);
    chk_val(n, 32);
    wr(8'h10, 8'h80);
    period(n);
    period(n);
    chk_val(n, 128);
    finish_test;
  end
endmodule
